// ==== core/memory_size_select.sv ====
// Memory size select register and pin function switch registers
`default_nettype none
module memory_size_select
  import memory_size_select_pkg::*;
(
  // Clock and reset
  input  wire logic     clk,
  input  wire logic     rst_n,
  // CPU byte access
  input  wire cpu_req_t cpu_req,
  output logic [7:0]    cpu_rdata,
  output logic          cpu_rvalid,
  // Memory map
  output mem_map_t      mem_map,
  output logic          write_rejected,
  // Pin function selection, 1 selects segment output
  output logic [7:0]    pin_function_switch_a,
  output logic [7:0]    pin_function_switch_b
);

  function automatic logic size_legal(input logic [7:0] v);
    size_legal = (v == MEM_SIZE_48K) || (v == MEM_SIZE_60K);
  endfunction : size_legal

  // Field pickers used by the map decode
  function automatic logic [2:0] hs_field(input logic [7:0] v);
    hs_field = v[HS_RAM_MSB:HS_RAM_LSB];
  endfunction : hs_field

  function automatic logic [3:0] prog_field(input logic [7:0] v);
    prog_field = v[PROG_MSB:PROG_LSB];
  endfunction : prog_field

  logic [7:0] memory_size_select_reg, memory_size_select_next;
  logic [7:0] pin_sw_a_reg,           pin_sw_a_next;
  logic [7:0] pin_sw_b_reg,           pin_sw_b_next;
  logic       rejected_reg,           rejected_next;
  logic [7:0] rdata_reg,              rdata_next;
  logic       rvalid_reg,             rvalid_next;
  logic       hit_size, hit_a, hit_b;

  assign hit_size = cpu_req.addr == MEM_SIZE_ADDR;
  assign hit_a    = cpu_req.addr == PIN_SW_A_ADDR;
  assign hit_b    = cpu_req.addr == PIN_SW_B_ADDR;

  // Writes
  always_comb begin
    memory_size_select_next = memory_size_select_reg;
    pin_sw_a_next           = pin_sw_a_reg;
    pin_sw_b_next           = pin_sw_b_reg;
    rejected_next           = rejected_reg;
    if (cpu_req.wr && hit_size) begin
      // Prohibited codes would break the map, so they never land
      if (size_legal(cpu_req.wdata)) begin
        memory_size_select_next = cpu_req.wdata & MEM_SIZE_KEEP;
        rejected_next           = 1'b0;
      end else begin
        rejected_next = 1'b1;
      end
    end
    if (cpu_req.wr && hit_a) begin
      pin_sw_a_next = cpu_req.wdata;
    end
    if (cpu_req.wr && hit_b) begin
      pin_sw_b_next = cpu_req.wdata;
    end
  end

  // Reads, answered one cycle later; unmapped reads give zero
  always_comb begin
    rvalid_next = cpu_req.rd;
    rdata_next  = rdata_reg;
    if (cpu_req.rd) begin
      if (hit_size) begin
        rdata_next = memory_size_select_reg;
      end else if (hit_a) begin
        rdata_next = pin_sw_a_reg;
      end else if (hit_b) begin
        rdata_next = pin_sw_b_reg;
      end else begin
        rdata_next = RDATA_NONE;
      end
    end
  end

  // Configuration group
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      memory_size_select_reg <= MEM_SIZE_RESET;
      pin_sw_a_reg           <= PIN_SW_RESET;
      pin_sw_b_reg           <= PIN_SW_RESET;
      rejected_reg           <= 1'b0;
    end else begin
      memory_size_select_reg <= memory_size_select_next;
      pin_sw_a_reg           <= pin_sw_a_next;
      pin_sw_b_reg           <= pin_sw_b_next;
      rejected_reg           <= rejected_next;
    end
  end

  // Read group
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg  <= RDATA_NONE;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // Map decode; prog_top is EFFFH for the 60 KB code and BFFFH otherwise
  always_comb begin
    mem_map.hs_ram_1024 = hs_field(memory_size_select_reg) == HS_RAM_1024;
    mem_map.prog_60k    = prog_field(memory_size_select_reg) == PROG_60K;
    mem_map.prog_top    = mem_map.prog_60k ? PROG_TOP_60K : PROG_TOP_48K;
  end

  assign cpu_rdata             = rdata_reg;
  assign cpu_rvalid            = rvalid_reg;
  assign write_rejected        = rejected_reg;
  assign pin_function_switch_a = pin_sw_a_reg;
  assign pin_function_switch_b = pin_sw_b_reg;

  a_reset_value_cf: assert property (@(posedge clk)
    $rose(rst_n) |-> memory_size_select_reg == MEM_SIZE_RESET)
    else $error("size register not CFH after reset");

  a_legal_write_lands: assert property (@(posedge clk) disable iff (!rst_n)
    cpu_req.wr && hit_size && size_legal(cpu_req.wdata)
    |=> memory_size_select_reg == $past(cpu_req.wdata) && !write_rejected)
    else $error("legal size write did not land");

  a_bad_write_kept: assert property (@(posedge clk) disable iff (!rst_n)
    cpu_req.wr && hit_size && !size_legal(cpu_req.wdata)
    |=> $stable(memory_size_select_reg) && write_rejected)
    else $error("prohibited size write changed register");

  a_bit4_zero: assert property (@(posedge clk) disable iff (!rst_n)
    cpu_req.rd && hit_size |=> cpu_rvalid && !cpu_rdata[ZERO_BIT])
    else $error("bit 4 read back nonzero");

  a_map_top_tracks: assert property (@(posedge clk) disable iff (!rst_n)
    memory_size_select_reg == MEM_SIZE_48K |-> mem_map.prog_top == PROG_TOP_48K
      && mem_map.hs_ram_1024)
    else $error("48 KB map not decoded");

  a_map_60k: assert property (@(posedge clk) disable iff (!rst_n)
    memory_size_select_reg == MEM_SIZE_60K |-> mem_map.prog_top == PROG_TOP_60K)
    else $error("60 KB map not decoded");

  a_pin_switch_write: assert property (@(posedge clk) disable iff (!rst_n)
    cpu_req.wr && hit_a |=> pin_function_switch_a == $past(cpu_req.wdata))
    else $error("pin switch A write lost");

  a_read_returns: assert property (@(posedge clk) disable iff (!rst_n)
    cpu_req.rd && hit_size ##0 !cpu_req.wr |=> cpu_rdata == memory_size_select_reg)
    else $error("size register read mismatch");

  a_size_always_legal: assert property (@(posedge clk) disable iff (!rst_n)
    size_legal(memory_size_select_reg))
    else $error("size register holds a prohibited code");

  a_bit4_held_zero: assert property (@(posedge clk) disable iff (!rst_n)
    !memory_size_select_reg[ZERO_BIT])
    else $error("bit 4 of size register set");

  a_hs_ram_decoded: assert property (@(posedge clk) disable iff (!rst_n)
    mem_map.hs_ram_1024)
    else $error("high-speed RAM size not decoded");

  a_map_48k_flag: assert property (@(posedge clk) disable iff (!rst_n)
    memory_size_select_reg == MEM_SIZE_48K |-> !mem_map.prog_60k)
    else $error("60 KB flag set for 48 KB code");

  a_size_hold_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !(cpu_req.wr && hit_size) |=> $stable(memory_size_select_reg))
    else $error("size register changed without a write");

  a_reject_held: assert property (@(posedge clk) disable iff (!rst_n)
    !(cpu_req.wr && hit_size) |=> $stable(write_rejected))
    else $error("reject flag changed without a write");

  a_switch_b_write: assert property (@(posedge clk) disable iff (!rst_n)
    cpu_req.wr && hit_b |=> pin_function_switch_b == $past(cpu_req.wdata))
    else $error("pin switch B write lost");

  a_switch_a_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !(cpu_req.wr && hit_a) |=> $stable(pin_function_switch_a))
    else $error("pin switch A changed without a write");

  a_switch_b_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !(cpu_req.wr && hit_b) |=> $stable(pin_function_switch_b))
    else $error("pin switch B changed without a write");

  a_switch_readback: assert property (@(posedge clk) disable iff (!rst_n)
    cpu_req.rd && hit_a |=> cpu_rdata == $past(pin_function_switch_a))
    else $error("pin switch A read mismatch");

  a_rvalid_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    !cpu_req.rd |=> !cpu_rvalid)
    else $error("read valid without a read");

  a_unmapped_read_zero: assert property (@(posedge clk) disable iff (!rst_n)
    cpu_req.rd && !hit_size && !hit_a && !hit_b |=> cpu_rdata == RDATA_NONE)
    else $error("unmapped read not zero");

  // Reset values are checked on release, since disable iff hides the reset itself
  a_reset_switches: assert property (@(posedge clk)
    $rose(rst_n) |-> pin_function_switch_a == PIN_SW_RESET
      && pin_function_switch_b == PIN_SW_RESET)
    else $error("pin switches not cleared by reset");

  a_reset_status: assert property (@(posedge clk)
    $rose(rst_n) |-> !write_rejected && !cpu_rvalid && cpu_rdata == RDATA_NONE)
    else $error("status outputs not idle after reset");

  a_reset_map: assert property (@(posedge clk)
    $rose(rst_n) |-> mem_map.prog_60k && mem_map.hs_ram_1024)
    else $error("reset map is not the 60 KB setting");

endmodule : memory_size_select
`default_nettype wire

// ==== core/memory_size_select_pkg.sv ====
// Constants and carrier types for the memory size select register block
// How it works
// - Reset loads the size register with CFH
// - Bits 7..5 must be 110, 1,024 bytes
// - Bits 3..0: 1100 is 48 KB, 1111 is 60 KB
// - Two switch registers pick port or segment pins
`default_nettype none
package memory_size_select_pkg;

  localparam logic [15:0] MEM_SIZE_ADDR    = 16'hfff0;
  localparam logic [15:0] PIN_SW_A_ADDR    = 16'hff78;
  localparam logic [15:0] PIN_SW_B_ADDR    = 16'hff79;
  localparam logic [7:0]  MEM_SIZE_RESET   = 8'hcf;
  localparam logic [7:0]  PIN_SW_RESET     = 8'h00;
  localparam logic [7:0]  MEM_SIZE_48K     = 8'hcc;
  localparam logic [7:0]  MEM_SIZE_60K     = 8'hcf;
  localparam logic [7:0]  MEM_SIZE_KEEP    = 8'hef;
  localparam logic [2:0]  HS_RAM_1024      = 3'h6;
  localparam logic [3:0]  PROG_48K         = 4'hc;
  localparam logic [3:0]  PROG_60K         = 4'hf;
  localparam logic [15:0] PROG_TOP_48K     = 16'hbfff;
  localparam logic [15:0] PROG_TOP_60K     = 16'hefff;
  localparam int          HS_RAM_LSB       = 5;
  localparam int          ZERO_BIT         = 4;
  localparam int          HS_RAM_MSB       = 7;
  localparam int          PROG_MSB         = 3;
  localparam int          PROG_LSB         = 0;
  localparam logic [7:0]  RDATA_NONE       = 8'h00;

  // One byte-wide CPU memory access
  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic [7:0]  wdata;
  } cpu_req_t;

  // Decoded memory map handed to the address decoders
  typedef struct packed {
    logic        hs_ram_1024;
    logic        prog_60k;
    logic [15:0] prog_top;
  } mem_map_t;

endpackage : memory_size_select_pkg
`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking bench for the memory size select register block
`default_nettype none
module tb
  import memory_size_select_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0]  d;
    logic [7:0]  q;
    logic        rej;
    logic [15:0] top;
  } row_t;
  logic     clk = 1'b0;
  logic     rst_n = 1'b0;
  cpu_req_t cpu_req = '0;
  logic [7:0] rdata, sw_a, sw_b;
  logic     rvalid, rej;
  mem_map_t mmap;
  int       errors = 0;
  int       checks = 0;
  // Refused values keep the last legal setting
  row_t rows[6] = '{'{8'hcc, 8'hcc, 1'b0, 16'hbfff}, '{8'hff, 8'hcc, 1'b1, 16'hbfff},
    '{8'hcf, 8'hcf, 1'b0, 16'hefff}, '{8'hcd, 8'hcf, 1'b1, 16'hefff},
    '{8'hdf, 8'hcf, 1'b1, 16'hefff}, '{8'hcc, 8'hcc, 1'b0, 16'hbfff}};
  always #4 clk = ~clk;
  memory_size_select dut_u (.clk(clk), .rst_n(rst_n), .cpu_req(cpu_req), .cpu_rdata(rdata),
    .cpu_rvalid(rvalid), .mem_map(mmap), .write_rejected(rej),
    .pin_function_switch_a(sw_a), .pin_function_switch_b(sw_b));
  task automatic end_of_test;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", name, exp, got);
    end
  endtask : chk
  // Byte access only; strobes stand until the next call replaces them
  task automatic acc(input logic [15:0] a, input logic w, input logic r, input logic [7:0] d);
    cpu_req = '{addr: a, wr: w, rd: r, wdata: d};
    @(posedge clk);
    #1;
  endtask : acc
  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string name);
    acc(a, 1'b0, 1'b1, 8'h00);
    chk(name, {8'h00, exp}, {8'h00, rdata});
    chk("rvalid", 16'h1, {15'h0, rvalid});
  endtask : rd
  initial begin
    #20000;
    errors++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk("top", 16'hefff, mmap.prog_top);
    rd(16'hfff0, 8'hcf, "reset size");
    foreach (rows[i]) begin
      acc(16'hfff0, 1'b1, 1'b0, rows[i].d);
      chk("rej", {15'h0, rows[i].rej}, {15'h0, rej});
      chk("top", rows[i].top, mmap.prog_top);
      chk("60k", {15'h0, rows[i].q == 8'hcf}, {15'h0, mmap.prog_60k});
      chk("hs", 16'h1, {15'h0, mmap.hs_ram_1024});
      rd(16'hfff0, rows[i].q, "size");
    end
    acc(16'hff78, 1'b1, 1'b0, 8'ha5);
    acc(16'hff79, 1'b1, 1'b0, 8'h3c);
    chk("sw", 16'ha53c, {sw_a, sw_b});
    rd(16'hff79, 8'h3c, "sw b");
    rd(16'hff78, 8'ha5, "sw a");
    rd(16'hff00, 8'h00, "unmapped");
    // Write and read together: the read sees the old value
    acc(16'hfff0, 1'b1, 1'b1, 8'hcf);
    chk("old", 16'hcc, {8'h00, rdata});
    rd(16'hfff0, 8'hcf, "new");
    acc(16'hfff0, 1'b1, 1'b0, 8'h00);
    cpu_req = '0;
    rst_n = 1'b0;
    #1;
    chk("rst rej", 16'h0, {15'h0, rej});
    chk("rst sw", 16'h0, {sw_a, sw_b});
    @(posedge clk);
    #1;
    rst_n = 1'b1;
    rd(16'hfff0, 8'hcf, "rereset");
    acc(16'hfff0, 1'b1, 1'b0, 8'hcc);
    chk("rvalid idle", 16'h0, {15'h0, rvalid});
    chk("top rewrite", 16'hbfff, mmap.prog_top);
    rd(16'hfff0, 8'hcc, "rewrite");
    end_of_test();
  end
endmodule : tb
`default_nettype wire
